// ### src/eph_epp_ecp_parallel_handshake.sv
// EPP cycle bridge and ECP / FIFO forward and ECP reverse handshake engine
module eph_epp_ecp_parallel_handshake import eph_pkg::*;
#(
	parameter int TIMEOUT = TIMEOUT_CYC
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [2:0] mode,
	input wire logic ecp_reverse,
	input wire logic port_direction_bit,
	input wire logic iow_n,
	input wire logic ior_n,
	input wire logic host_addr_sel,
	input wire logic [7:0] host_data_lines_in,
	output logic [7:0] host_data_lines_out,
	output logic host_data_lines_oe,
	output logic iochrdy,
	input wire logic [7:0] cable_data_lines_in,
	output logic [7:0] cable_data_lines_out,
	output logic cable_data_lines_oe,
	output logic write_n,
	output logic data_strobe_n,
	output logic addr_strobe_n,
	input wire logic wait_n,
	output logic strobe_n,
	output logic autofd_n,
	input wire logic busy,
	input wire logic ack_n,
	input wire logic fault_n,
	output logic periph_request,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output logic [7:0] rx_data,
	input wire logic rx_ready,
	output logic epp_timeout
);
	typedef struct packed {
		eph_epp_st_t epp_st;
		eph_ecp_st_t ecp_st;
		logic [CNT_W-1:0] cnt;
		logic write_n;
		logic dstb_n;
		logic astb_n;
		logic iochrdy;
		logic [7:0] hdata;
		logic hdata_oe;
		logic [7:0] cdata;
		logic cdata_oe;
		logic strobe_n;
		logic autofd_n;
		logic tx_ready;
		logic [7:0] rx_data;
		logic rx_valid;
		logic timeout;
		logic periph_req;
	} eph_state_t;

	localparam eph_state_t ST_RST = '{
		epp_st: E_IDLE, ecp_st: C_IDLE, cnt: '0, write_n: 1'b1, dstb_n: 1'b1,
		astb_n: 1'b1, iochrdy: 1'b1, hdata: '0, hdata_oe: 1'b0, cdata: '0,
		cdata_oe: 1'b0, strobe_n: 1'b1, autofd_n: 1'b1, tx_ready: 1'b0,
		rx_data: '0, rx_valid: 1'b0, timeout: 1'b0, periph_req: 1'b0};

	eph_state_t q, d;
	logic [2:0] raw_in;
	logic [2:0] settled;
	logic wait_s;
	logic busy_s;
	logic ack_s;
	logic tmr_run;
	logic tmr_exp;
	logic is_epp;
	logic is_fifo;
	logic fwd;
	logic answered;

	// ----------------------------------------------------------------
	// cable input filters
	// ----------------------------------------------------------------
	assign raw_in = {ack_n, busy, wait_n};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_flt
			eph_settle_filter #(
				.STABLE(SETTLE_CYC),
				.RST(FLT_RST[gi])
			) u_flt (
				.clk(clk),
				.resetn(resetn),
				.raw(raw_in[gi]),
				.settled(settled[gi])
			);
		end
	endgenerate

	assign wait_s = settled[FLT_WAIT];
	assign busy_s = settled[FLT_BUSY];
	assign ack_s = settled[FLT_ACK];

	// ----------------------------------------------------------------
	// EPP handshake timeout
	// ----------------------------------------------------------------
	assign tmr_run = (q.epp_st == E_WR_CMD || q.epp_st == E_RD_CMD) && !q.iochrdy;

	eph_cycle_timer #(
		.LIMIT(TIMEOUT)
	) u_tmr (
		.clk(clk),
		.resetn(resetn),
		.run(tmr_run),
		.expired(tmr_exp)
	);

	assign is_epp = (mode == MODE_EPP);
	assign is_fifo = (mode == MODE_FIFO);
	assign fwd = is_fifo || (mode == MODE_ECP && !ecp_reverse);
	// peripheral wait is active low; expiry stands in for a missing answer
	assign answered = !wait_s || tmr_exp;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d = q;
		d.tx_ready = 1'b0;
		d.periph_req = !fault_n; // RULE15
		if (rx_ready && q.rx_valid)
			d.rx_valid = 1'b0;
		if (is_epp)
		begin
			unique case (q.epp_st)
				E_IDLE:
				begin
					d.write_n = 1'b1; // RULE2
					d.dstb_n = 1'b1;
					d.astb_n = 1'b1;
					d.iochrdy = 1'b1;
					d.hdata_oe = 1'b0;
					if (!iow_n)
					begin
						d.timeout = 1'b0;
						d.iochrdy = 1'b0; // RULE5
						d.cdata = host_data_lines_in;
						d.cdata_oe = 1'b1;
						// a set direction bit keeps the cable in read state
						d.write_n = port_direction_bit; // RULE3
						d.epp_st = E_WR_SETUP;
					end
					else if (!ior_n)
					begin
						d.timeout = 1'b0;
						d.iochrdy = 1'b0;
						d.cdata_oe = 1'b0; // RULE4
						d.dstb_n = host_addr_sel;
						d.astb_n = !host_addr_sel; // RULE8
						d.epp_st = E_RD_CMD;
					end
				end
				E_WR_SETUP:
				begin
					// data went out one cycle before the strobe falls
					d.dstb_n = host_addr_sel; // RULE7
					d.astb_n = !host_addr_sel;
					d.epp_st = E_WR_CMD;
				end
				E_WR_CMD:
				begin
					if (answered)
					begin
						d.iochrdy = 1'b1; // RULE9
						d.timeout = q.timeout || tmr_exp; // RULE21
					end
					if (iow_n)
					begin
						d.dstb_n = 1'b1; // RULE6
						d.astb_n = 1'b1;
						d.iochrdy = 1'b1;
						d.cnt = CMD_HOLD_CNT;
						d.epp_st = E_WR_HOLD;
					end
				end
				E_WR_HOLD:
				begin
					d.write_n = 1'b1;
					// data held past the command edge for the peripheral
					if (q.cnt == '0)
					begin
						d.cdata_oe = 1'b0;
						d.epp_st = E_IDLE;
					end
					else
						d.cnt = q.cnt - CNT_W'(1);
				end
				E_RD_CMD:
				begin
					if (answered)
					begin
						d.iochrdy = 1'b1; // RULE9
						d.timeout = q.timeout || tmr_exp; // RULE21
						d.hdata = cable_data_lines_in;
						d.hdata_oe = 1'b1;
					end
					if (ior_n)
					begin
						d.dstb_n = 1'b1;
						d.astb_n = 1'b1;
						d.iochrdy = 1'b1;
						d.hdata_oe = 1'b0; // RULE10
						d.epp_st = E_IDLE;
					end
				end
				default:
					d.epp_st = E_IDLE;
			endcase
		end
		else
		begin
			unique case (q.ecp_st)
				C_IDLE:
				begin
					d.strobe_n = 1'b1; // RULE13
					d.autofd_n = 1'b1;
					if (mode == MODE_ECP && ecp_reverse)
					begin
						// turnaround only between the two idle phases
						d.cdata_oe = 1'b0; // RULE17
						d.autofd_n = 1'b0;
						d.ecp_st = C_REV_IDLE;
					end
					else if (q.tx_ready && tx_valid)
					begin
						d.cdata = tx_data;
						d.cdata_oe = 1'b1;
						d.cnt = is_fifo ? FIFO_SETUP_CNT : '0;
						d.ecp_st = C_SETUP;
					end
				end
				C_SETUP:
				begin
					if (q.cnt == '0)
					begin
						d.strobe_n = 1'b0; // RULE16
						d.cnt = FIFO_STROBE_CNT;
						d.ecp_st = C_CLK;
					end
					else
						d.cnt = q.cnt - CNT_W'(1);
				end
				C_CLK:
				begin
					if (is_fifo)
					begin
						// acknowledge is never looked at in this mode
						if (q.cnt == '0)
						begin
							d.strobe_n = 1'b1; // RULE11
							d.cnt = FIFO_HOLD_CNT;
							d.ecp_st = C_HOLD;
						end
						else
							d.cnt = q.cnt - CNT_W'(1);
					end
					else if (busy_s)
					begin
						d.strobe_n = 1'b1; // RULE14
						d.ecp_st = C_REL;
					end
				end
				C_REL:
				begin
					if (!busy_s)
						d.ecp_st = C_IDLE; // RULE14
				end
				C_HOLD:
				begin
					if (q.cnt == '0)
						d.ecp_st = C_IDLE; // RULE12
					else
						d.cnt = q.cnt - CNT_W'(1);
				end
				C_REV_IDLE:
				begin
					d.autofd_n = 1'b0; // RULE18
					if (mode != MODE_ECP || !ecp_reverse)
					begin
						d.autofd_n = 1'b1;
						d.ecp_st = C_IDLE; // RULE17
					end
					else if (!ack_s && !q.rx_valid)
					begin
						// a full slot stalls the peripheral with ack low
						d.rx_data = cable_data_lines_in; // RULE19
						d.rx_valid = 1'b1;
						d.autofd_n = 1'b1;
						d.ecp_st = C_REV_REL;
					end
				end
				C_REV_REL:
				begin
					if (ack_s)
					begin
						d.autofd_n = 1'b0; // RULE19
						d.ecp_st = C_REV_IDLE;
					end
				end
				default:
					d.ecp_st = C_IDLE;
			endcase
			// busy high blocks the next byte in both forward modes
			d.tx_ready = (d.ecp_st == C_IDLE) && fwd && !busy_s && !(q.tx_ready && tx_valid); // RULE12
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= ST_RST;
		else
			q <= d;
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign host_data_lines_out = q.hdata;
	assign host_data_lines_oe = q.hdata_oe;
	assign iochrdy = q.iochrdy;
	assign cable_data_lines_out = q.cdata;
	assign cable_data_lines_oe = q.cdata_oe;
	assign write_n = q.write_n;
	assign data_strobe_n = q.dstb_n;
	assign addr_strobe_n = q.astb_n;
	assign strobe_n = q.strobe_n;
	assign autofd_n = q.autofd_n;
	assign periph_request = q.periph_req;
	assign tx_ready = q.tx_ready;
	assign rx_valid = q.rx_valid;
	assign rx_data = q.rx_data;
	assign epp_timeout = q.timeout;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_write_dir_idle: assert property (@(posedge clk) disable iff (!resetn) // RULE2
		(q.epp_st == E_IDLE || q.epp_st == E_RD_CMD) |-> write_n)
		else $error("write direction low outside a write");
	a_write_dir_bit: assert property (@(posedge clk) disable iff (!resetn) // RULE3
		(is_epp && q.epp_st == E_IDLE && !iow_n) |=> (write_n == $past(port_direction_bit)))
		else $error("write direction does not follow direction bit");
	a_ready_prompt: assert property (@(posedge clk) disable iff (!resetn) // RULE5
		(is_epp && q.epp_st == E_IDLE && !iow_n) |=> !iochrdy ##1 (!iochrdy || tmr_exp || !wait_s))
		else $error("host ready not dropped after write strobe");
	a_cmd_release: assert property (@(posedge clk) disable iff (!resetn) // RULE6
		(is_epp && q.epp_st == E_WR_CMD && iow_n) |=> (data_strobe_n && addr_strobe_n))
		else $error("command strobe late after write strobe end");
	a_data_before_cmd: assert property (@(posedge clk) disable iff (!resetn) // RULE7
		$fell(data_strobe_n && addr_strobe_n) && write_n == 1'b0 |->
		$past(cable_data_lines_oe) && $stable(cable_data_lines_out))
		else $error("cable data not valid before command strobe");
	a_read_cmd_fast: assert property (@(posedge clk) disable iff (!resetn) // RULE8
		(is_epp && q.epp_st == E_IDLE && iow_n && !ior_n) |=> (!data_strobe_n || !addr_strobe_n))
		else $error("read command strobe late");
	a_wait_release: assert property (@(posedge clk) disable iff (!resetn) // RULE9
		(is_epp && (q.epp_st == E_WR_CMD || q.epp_st == E_RD_CMD) && !wait_s) |=> iochrdy)
		else $error("host wait kept after peripheral answered");
	a_read_bus_off: assert property (@(posedge clk) disable iff (!resetn) // RULE10
		ior_n |=> !host_data_lines_oe)
		else $error("host data driven after read strobe");
	a_fifo_strobe_width: assert property (@(posedge clk) disable iff (!resetn) // RULE11
		(is_fifo && $fell(strobe_n)) |-> !strobe_n [*8])
		else $error("FIFO strobe pulse too short");
	a_fwd_idle_clk: assert property (@(posedge clk) disable iff (!resetn) // RULE13
		(!is_epp && (q.ecp_st == C_IDLE || q.ecp_st == C_REV_IDLE)) |-> strobe_n)
		else $error("host clock low in idle");
	a_fwd_interlock: assert property (@(posedge clk) disable iff (!resetn) // RULE14
		(mode == MODE_ECP && q.ecp_st == C_CLK && busy_s) |=> strobe_n && q.ecp_st == C_REL)
		else $error("host clock not raised after busy");
	a_rev_idle_ack: assert property (@(posedge clk) disable iff (!resetn) // RULE18
		(q.ecp_st == C_REV_IDLE) |-> !autofd_n)
		else $error("host acknowledge high in reverse idle");
	a_timeout_end: assert property (@(posedge clk) disable iff (!resetn) // RULE21
		(is_epp && tmr_exp && (q.epp_st == E_WR_CMD || q.epp_st == E_RD_CMD)) |=>
		iochrdy && epp_timeout)
		else $error("timeout did not end the cycle");
endmodule

// ### src/eph_pkg.sv
// constants, codes and state types of the parallel handshake engine
// Functional notes
// [RULE1] wait input counts as settled only after 50 ns without a transition
// [RULE2] write-direction output stays high outside an EPP write cycle
// [RULE3] host clears the direction bit before an EPP write
// [RULE4] host sets the direction bit before an EPP read
// [RULE5] host ready drops right after write strobe, held until peripheral answers
// [RULE6] command strobe ends within 50 ns of the host write strobe ending
// [RULE7] cable data valid at least 10 ns before command strobe falls
// [RULE8] read command strobe asserts within 55 ns of host read strobe
// [RULE9] host wait released within about 40 ns of peripheral wait assertion; the code needs about four 25 ns clocks, behind the settle filter
// [RULE10] host data bus released within 40 ns after read strobe ends
// [RULE11] FIFO mode sends forward stream bytes at up to about 500 Kbps; the code needs 67 clocks of 25 ns per byte, up to about 600 K bytes/s
// [RULE12] FIFO mode ignores acknowledge, paces bytes on busy only
// [RULE13] forward idle keeps host clock high, peripheral keeps busy low
// [RULE14] forward byte: busy low, clock low, busy high, clock high, busy low
// [RULE15] peripheral request may arrive at any time during forward phase
// [RULE16] forward data stable before host clock falls
// [RULE17] forward phase entered from forward idle, reverse from reverse idle
// [RULE18] reverse idle keeps peripheral clock high, host acknowledge low
// [RULE19] reverse byte: ack low, clock low, ack high, clock high, ack low
// [RULE20] peripheral keeps reverse data stable before its clock falls
// [RULE21] unanswered EPP cycle ends after a timeout, flagging it
package eph_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_NS = 50;
	localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
	localparam int TIMEOUT_US = 10;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
	localparam int CMD_HOLD_NS = 50;
	localparam int FIFO_SETUP_NS = 600;
	localparam int FIFO_STROBE_NS = 600;
	localparam int FIFO_HOLD_NS = 450;
	localparam int CNT_W = 5;
	// counters load cycles minus one, rounded up first
	localparam logic [CNT_W-1:0] CMD_HOLD_CNT =
		CNT_W'((CMD_HOLD_NS * CLK_MHZ + 999) / 1000 - 1);
	localparam logic [CNT_W-1:0] FIFO_SETUP_CNT =
		CNT_W'((FIFO_SETUP_NS * CLK_MHZ + 999) / 1000 - 1);
	localparam logic [CNT_W-1:0] FIFO_STROBE_CNT =
		CNT_W'((FIFO_STROBE_NS * CLK_MHZ + 999) / 1000 - 1);
	localparam logic [CNT_W-1:0] FIFO_HOLD_CNT =
		CNT_W'((FIFO_HOLD_NS * CLK_MHZ + 999) / 1000 - 1);
	// ----------------------------------------------------------------
	// modes and filter channels
	// ----------------------------------------------------------------
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_EPP = 3'h4;
	localparam logic [2:0] MODE_FIFO = 3'h5;
	localparam int FLT_WAIT = 0;
	localparam int FLT_BUSY = 1;
	localparam int FLT_ACK = 2;
	localparam logic [2:0] FLT_RST = 3'h5;
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		E_IDLE = 3'h0,
		E_WR_SETUP = 3'h1,
		E_WR_CMD = 3'h2,
		E_WR_HOLD = 3'h3,
		E_RD_CMD = 3'h4
	} eph_epp_st_t;
	typedef enum logic [2:0] {
		C_IDLE = 3'h0,
		C_SETUP = 3'h1,
		C_CLK = 3'h2,
		C_REL = 3'h3,
		C_HOLD = 3'h4,
		C_REV_IDLE = 3'h5,
		C_REV_REL = 3'h6
	} eph_ecp_st_t;
endpackage

// ### src/eph_settle_filter.sv
// settle filter: passes a level once it has stopped changing
module eph_settle_filter import eph_pkg::*;
#(
	parameter int STABLE = 2,
	parameter logic RST = 1'b1
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic raw,
	output logic settled
);
	localparam int CW = $clog2(STABLE + 1);
	typedef struct packed {
		logic last;
		logic [CW-1:0] cnt;
		logic settled;
	} eph_flt_t;
	eph_flt_t q, d;

	always_comb
	begin
		d = q;
		d.last = raw;
		if (raw != q.last)
			d.cnt = '0;
		else if (q.cnt != CW'(STABLE))
			d.cnt = q.cnt + CW'(1);
		if (d.cnt == CW'(STABLE))
			d.settled = raw; // RULE1
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= '{last: RST, cnt: '0, settled: RST};
		else
			q <= d;
	end

	assign settled = q.settled;

	a_settle_stable: assert property (@(posedge clk) disable iff (!resetn) // RULE1
		$changed(q.settled) |-> ($past(raw, 1) == $past(raw, 2)) && (q.settled == $past(raw, 1)))
		else $error("settled level changed on an unstable input");
endmodule

// ### src/eph_cycle_timer.sv
// cycle timer: raises expired after LIMIT cycles of run
module eph_cycle_timer import eph_pkg::*;
#(
	parameter int LIMIT = 400
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	output logic expired
);
	localparam int CW = $clog2(LIMIT + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic expired;
	} eph_tmr_t;
	eph_tmr_t q, d;

	always_comb
	begin
		d = q;
		if (!run)
		begin
			d.cnt = '0;
			d.expired = 1'b0;
		end
		else if (q.cnt == CW'(LIMIT - 1))
			d.expired = 1'b1;
		else
			d.cnt = q.cnt + CW'(1);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= '0;
		else
			q <= d;
	end

	assign expired = q.expired;

	a_timer_clear: assert property (@(posedge clk) disable iff (!resetn) // RULE21
		!run |=> !expired)
		else $error("timer expired without running");
endmodule

// ### testbench/eph_periph_model.sv
// cable-side peripheral model for the parallel handshake engine
module eph_periph_model
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [3:0] dly,
	input wire logic mute,
	input wire logic rev_go,
	input wire logic ack_force,
	input wire logic req,
	input wire logic [7:0] reply,
	input wire logic data_strobe_n,
	input wire logic addr_strobe_n,
	input wire logic strobe_n,
	input wire logic autofd_n,
	input wire logic [7:0] cable_data_lines_out,
	output logic [7:0] cable_data_lines_in,
	output logic wait_n,
	output logic busy,
	output logic ack_n,
	output logic fault_n,
	output logic [7:0] got
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// handshakes
	// ----------------------------------------------------------------
	logic [3:0] cnt_q;
	logic ack_q;
	logic done_q;
	logic cmd;
	assign cmd = !(data_strobe_n && addr_strobe_n);
	// undriven lines show the inverse so stale data never matches
	assign cable_data_lines_in = (cmd || (rev_go && !done_q)) ? reply : ~reply;
	assign ack_n = ack_q && !ack_force;
	assign fault_n = !req;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q <= 4'h0;
			wait_n <= 1'b1;
			busy <= 1'b0;
			ack_q <= 1'b1;
			done_q <= 1'b0;
			got <= 8'h00;
		end
		else
		begin
			// saturate so a long host strobe never re-raises wait
			cnt_q <= !cmd ? 4'h0 : (cnt_q == 4'hF ? cnt_q : cnt_q + 4'h1);
			wait_n <= !(cmd && !mute && cnt_q >= dly);
			busy <= !strobe_n;
			if (!strobe_n)
				got <= cable_data_lines_out;
			if (!autofd_n && rev_go && !done_q)
				ack_q <= 1'b0;
			if (autofd_n && !ack_q)
			begin
				ack_q <= 1'b1;
				done_q <= 1'b1;
			end
			if (!rev_go)
				done_q <= 1'b0;
		end
	end
endmodule

// ### testbench/tb_eph_epp_ecp_parallel_handshake.sv
// self-checking bench of the parallel handshake engine
module tb_eph_epp_ecp_parallel_handshake import eph_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [2:0] mode = MODE_EPP;
	logic ecp_reverse = 1'b0, port_direction_bit = 1'b1, iow_n = 1'b1, ior_n = 1'b1;
	logic host_addr_sel = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
	logic [7:0] host_data_lines_in = 8'h00, tx_data = 8'h00, reply = 8'h00;
	logic [3:0] dly = 4'h0;
	logic mute = 1'b0, rev_go = 1'b0, ack_force = 1'b0, req = 1'b0;
	logic [7:0] host_data_lines_out, cable_data_lines_in, cable_data_lines_out, rx_data, got;
	logic host_data_lines_oe, iochrdy, cable_data_lines_oe, write_n, data_strobe_n;
	logic addr_strobe_n, wait_n, strobe_n, autofd_n, busy, ack_n, fault_n;
	logic periph_request, tx_ready, rx_valid, epp_timeout;
	int n_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	always #12.5 clk = ~clk;
	eph_epp_ecp_parallel_handshake #(.TIMEOUT(20)) uut (.clk(clk), .resetn(resetn),
		.mode(mode), .ecp_reverse(ecp_reverse), .port_direction_bit(port_direction_bit),
		.iow_n(iow_n), .ior_n(ior_n), .host_addr_sel(host_addr_sel),
		.host_data_lines_in(host_data_lines_in), .host_data_lines_out(host_data_lines_out),
		.host_data_lines_oe(host_data_lines_oe), .iochrdy(iochrdy),
		.cable_data_lines_in(cable_data_lines_in), .cable_data_lines_out(cable_data_lines_out),
		.cable_data_lines_oe(cable_data_lines_oe), .write_n(write_n),
		.data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n), .wait_n(wait_n),
		.strobe_n(strobe_n), .autofd_n(autofd_n), .busy(busy), .ack_n(ack_n),
		.fault_n(fault_n), .periph_request(periph_request), .tx_valid(tx_valid),
		.tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_ready(rx_ready), .epp_timeout(epp_timeout));
	eph_periph_model peer (.clk(clk), .resetn(resetn), .dly(dly), .mute(mute),
		.rev_go(rev_go), .ack_force(ack_force), .req(req), .reply(reply),
		.data_strobe_n(data_strobe_n), .addr_strobe_n(addr_strobe_n), .strobe_n(strobe_n),
		.autofd_n(autofd_n), .cable_data_lines_out(cable_data_lines_out),
		.cable_data_lines_in(cable_data_lines_in), .wait_n(wait_n), .busy(busy),
		.ack_n(ack_n), .fault_n(fault_n), .got(got));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic end_sim;
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		tests_run++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk1(input logic g, input logic e);
		chk({7'h00, g}, {7'h00, e});
	endtask
	task automatic cyc;
		@(posedge clk);
		#1;
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic epp_write(input logic sel, input logic [7:0] d, input logic [3:0] w);
		logic [7:0] pd;
		logic po;
		@(posedge clk);
		port_direction_bit <= 1'b0;
		host_addr_sel <= sel;
		host_data_lines_in <= d;
		dly <= w;
		iow_n <= 1'b0;
		cyc;
		while (data_strobe_n && addr_strobe_n)
		begin
			pd = cable_data_lines_out;
			po = cable_data_lines_oe;
			cyc;
			chk1(iochrdy, 1'b0);
		end
		chk(pd, d);
		chk1(po, 1'b1);
		chk1(write_n, 1'b0);
		chk1(sel ? addr_strobe_n : data_strobe_n, 1'b0);
		chk1(epp_timeout, 1'b0);
		while (wait_n)
			cyc;
		n = 0;
		while (!iochrdy)
		begin
			cyc;
			n++;
		end
		chk1(n >= 2 && n <= 4, 1'b1);
		@(posedge clk);
		iow_n <= 1'b1;
		n = 0;
		cyc;
		while (!(data_strobe_n && addr_strobe_n))
		begin
			cyc;
			n++;
		end
		chk1(n <= 1, 1'b1);
		repeat (2) cyc;
		chk1(write_n, 1'b1);
		repeat (4) cyc;
	endtask
	task automatic epp_read(input logic sel, input logic [7:0] d);
		@(posedge clk);
		port_direction_bit <= 1'b1;
		host_addr_sel <= sel;
		reply <= d;
		dly <= 4'h3;
		ior_n <= 1'b0;
		n = 0;
		cyc;
		while (data_strobe_n && addr_strobe_n)
		begin
			cyc;
			n++;
		end
		chk1(n <= 1, 1'b1);
		chk1(write_n, 1'b1);
		chk1(sel ? addr_strobe_n : data_strobe_n, 1'b0);
		while (!iochrdy)
			cyc;
		chk(host_data_lines_out, d);
		chk1(host_data_lines_oe, 1'b1);
		@(posedge clk);
		ior_n <= 1'b1;
		repeat (2) cyc;
		chk1(host_data_lines_oe, 1'b0);
		repeat (4) cyc;
	endtask
	task automatic epp_dead;
		@(posedge clk);
		mute <= 1'b1;
		port_direction_bit <= 1'b0;
		iow_n <= 1'b0;
		n = 0;
		repeat (2) cyc;
		while (!iochrdy)
		begin
			cyc;
			n++;
		end
		chk1(n >= 17 && n <= 23, 1'b1);
		chk1(epp_timeout, 1'b1);
		@(posedge clk);
		iow_n <= 1'b1;
		mute <= 1'b0;
		repeat (6) cyc;
	endtask
	task automatic fifo_send(input logic [7:0] d);
		@(posedge clk);
		mode <= MODE_FIFO;
		ack_force <= 1'b1;
		tx_data <= d;
		tx_valid <= 1'b1;
		cyc;
		while (!tx_ready)
			cyc;
		@(posedge clk);
		tx_valid <= 1'b0;
		#1;
		n = 0;
		while (strobe_n)
		begin
			cyc;
			n++;
		end
		chk1(n >= 24, 1'b1);
		chk(cable_data_lines_out, d);
		n = 0;
		while (!strobe_n)
		begin
			cyc;
			n++;
		end
		chk1(n >= 24, 1'b1);
		chk(got, d);
		while (!tx_ready)
			cyc;
		@(posedge clk);
		ack_force <= 1'b0;
	endtask
	task automatic ecp_fwd(input logic [7:0] d);
		@(posedge clk);
		mode <= MODE_ECP;
		tx_data <= d;
		req <= 1'b1;
		cyc;
		// ready may already stand from the last byte: offer only once it is seen
		while (!tx_ready)
			cyc;
		@(posedge clk);
		tx_valid <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b0;
		#1;
		while (strobe_n)
			cyc;
		chk1(busy, 1'b0);
		chk(cable_data_lines_out, d);
		chk1(periph_request, 1'b1);
		while (!strobe_n)
			cyc;
		chk1(busy, 1'b1);
		chk(got, d);
		@(posedge clk);
		req <= 1'b0;
		#1;
		while (busy)
			cyc;
		repeat (3) cyc;
		chk1(strobe_n, 1'b1);
	endtask
	task automatic ecp_rev(input logic [7:0] a, input logic [7:0] b);
		@(posedge clk);
		ecp_reverse <= 1'b1;
		reply <= a;
		rev_go <= 1'b1;
		cyc;
		while (autofd_n)
			cyc;
		chk1(ack_n, 1'b1);
		while (!rx_valid)
			cyc;
		chk(rx_data, a);
		chk1(autofd_n, 1'b1);
		while (autofd_n)
			cyc;
		@(posedge clk);
		rev_go <= 1'b0;
		@(posedge clk);
		reply <= b;
		rev_go <= 1'b1;
		repeat (12) cyc;
		chk(rx_data, a);
		chk1(autofd_n, 1'b0);
		@(posedge clk);
		rx_ready <= 1'b1;
		@(posedge clk);
		rx_ready <= 1'b0;
		#1;
		while (!rx_valid)
			cyc;
		chk(rx_data, b);
		@(posedge clk);
		rx_ready <= 1'b1;
		rev_go <= 1'b0;
		@(posedge clk);
		rx_ready <= 1'b0;
		ecp_reverse <= 1'b0;
		repeat (6) cyc;
	endtask
	// ----------------------------------------------------------------
	// sequence and watchdog
	// ----------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		cyc;
		chk1(iochrdy, 1'b1);
		chk1(write_n, 1'b1);
		chk1(strobe_n, 1'b1);
		chk1(autofd_n, 1'b1);
		epp_write(1'b0, 8'hA5, 4'h0);
		epp_write(1'b1, 8'h3C, 4'h6);
		epp_read(1'b0, 8'h5A);
		epp_read(1'b1, 8'hC3);
		epp_dead;
		epp_write(1'b0, 8'h81, 4'h2);
		fifo_send(8'h96);
		ecp_fwd(8'h7E);
		ecp_fwd(8'h18);
		ecp_rev(8'hE7, 8'h42);
		end_sim;
	end
	// the whole run needs well under two thousand cycles
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles > 5000)
		begin
			n_errors++;
			end_sim;
		end
	end
endmodule
